// ===== design/iod_defs.svh
// constants of the instruction operand decoder
`ifndef IOD_DEFS_SVH
`define IOD_DEFS_SVH
// widths
`define IOD_WORD_W 14
`define IOD_FADDR_W 7
`define IOD_PC_W 13
`define IOD_LATCH_W 5
// timing: oscillator periods per instruction cycle
`define IOD_QUARTERS 4
// special file addresses
`define IOD_ADDR_PCL 7'h02
`define IOD_ADDR_STATUS 7'h03
`define IOD_ADDR_LATCH 7'h0a
// status flag positions
`define IOD_ST_C 0
`define IOD_ST_DC 1
`define IOD_ST_Z 2
// reset values
`define IOD_STATUS_RST 8'h00
`define IOD_LATCH_RST 5'h00
`define IOD_PC_RST 13'h0000
`define IOD_NOP_WORD 14'h0000
// status after clearing it with the clear-file op
`define IOD_STATUS_CLR 8'h04
`endif

// ===== design/iod_pkg.sv
// types of the instruction operand decoder
`include "iod_defs.svh"
package iod_pkg;
  typedef enum logic [1:0] {IOD_PH_Q1, IOD_PH_Q2, IOD_PH_Q3, IOD_PH_Q4} iod_phase_e;
  typedef enum logic [1:0] {IOD_CLS_BYTE, IOD_CLS_BIT, IOD_CLS_LIT} iod_class_e;
  typedef struct packed {
    iod_phase_e ph;
    logic [`IOD_WORD_W-1:0] ir;
    logic [`IOD_PC_W-1:0] pc;
    logic [`IOD_LATCH_W-1:0] latch;
    logic [7:0] status;
    logic nop;
    logic [7:0] operand;
    logic [7:0] wdata;
  } iod_state_s;
endpackage

// ===== design/iod_field.sv
// operand field extraction of one instruction word
`timescale 1ns/1ps
`default_nettype none
`include "iod_defs.svh"
module iod_field #(
  parameter int WORD_W = `IOD_WORD_W
) (
  // instruction word
  input wire logic [WORD_W-1:0] word,
  // decoded fields
  output iod_pkg::iod_class_e cls,
  output logic [`IOD_FADDR_W-1:0] faddr,
  output logic [2:0] bit_idx,
  output logic dest_f
);
  import iod_pkg::*;
  logic ctl;
  // control words sit in the byte space with a zero opcode nibble
  assign ctl = (word[13:7] == 7'h00) && (word[3:0] != 4'h0);
  // class from the top two bits, plus bits 13:7 and 3:0 for control words; don't-care bits never matter
  always_comb begin
    if (word[13:12] == 2'b01) begin
      cls = IOD_CLS_BIT;
    end else if (word[13] || ctl) begin
      cls = IOD_CLS_LIT;
    end else begin
      cls = IOD_CLS_BYTE;
    end
  end
  // fixed field positions of the 14-bit word
  assign faddr = word[6:0];
  assign bit_idx = word[9:7];
  // bit ops always return to the file, literals to w
  assign dest_f = (cls == IOD_CLS_BIT) || ((cls == IOD_CLS_BYTE) && word[7]);
endmodule
`default_nettype wire

// ===== design/iod_core.sv
// instruction decode and cycle timing of the 8-bit core
`timescale 1ns/1ps
`default_nettype none
`include "iod_defs.svh"
// Function
// - each instruction is one 14-bit word of opcode and operand fields
// - every word falls in byte, bit, or literal-and-control class
// - file address is a seven-bit field, 0x00 to 0x7F
// - bit index picks one of eight bits of the file register
// - destination bit 0 writes w, 1 writes the file register
// - don't-care bits never change decoding or behaviour
// - one cycle per word; skip or pc change adds a nop cycle
// - one instruction cycle is four oscillator periods
// - status writes take produced zero, carry, digit carry over data
// - clearing status leaves 0000 0100b
// - reading pc low byte gives current pc low eight bits
// - writing pc low byte also loads high part from holding latch
// - read-modify-write of pc low byte uses it as alu operand
module iod_core (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // program memory and stack
  output logic [`IOD_PC_W-1:0] fetch_addr,
  input wire logic [`IOD_WORD_W-1:0] instr_word,
  input wire logic [`IOD_PC_W-1:0] stack_top,
  // decoded executing word
  output logic [`IOD_WORD_W-1:0] exec_word,
  output iod_pkg::iod_class_e exec_class,
  output iod_pkg::iod_phase_e exec_phase,
  output logic [`IOD_FADDR_W-1:0] file_addr,
  output logic [2:0] bit_index,
  output logic dest_is_file,
  output logic nop_cycle,
  // alu
  output logic [7:0] alu_operand,
  input wire logic [7:0] alu_result,
  input wire logic alu_z,
  input wire logic alu_c,
  input wire logic alu_dc,
  input wire logic [2:0] alu_flag_we,
  // file registers and w
  input wire logic [7:0] file_rdata,
  output logic file_we,
  output logic w_we,
  output logic [7:0] result_data,
  // special registers
  output logic [7:0] status_reg,
  output logic [`IOD_LATCH_W-1:0] pc_high_holding_latch
);
  import iod_pkg::*;
  iod_state_s s_q;
  iod_state_s s_d;
  iod_class_e cls;
  logic [`IOD_FADDR_W-1:0] faddr;
  logic [2:0] bidx;
  logic dest_f;
  logic wr_res;
  logic skip;
  logic branch;
  logic [`IOD_PC_W-1:0] target;
  logic [7:0] src;
  logic go;
  logic pcl_wr;
  logic st_wr;
  logic latch_wr;
  logic two;
  logic [7:0] st_new;

  // ==========================================================
  // field decode
  iod_field #(.WORD_W(`IOD_WORD_W)) u_field (
    .word(s_q.ir),
    .cls(cls),
    .faddr(faddr),
    .bit_idx(bidx),
    .dest_f(dest_f)
  );

  // ==========================================================
  // per-class behaviour; x bits are never looked at
  always_comb begin
    wr_res = 1'b0;
    skip = 1'b0;
    branch = 1'b0;
    target = stack_top;
    case (cls)
      IOD_CLS_BYTE: begin
        // zero nibble: move-w-to-file writes, the nop does not
        wr_res = (s_q.ir[11:8] == 4'h0) ? s_q.ir[7] : 1'b1;
        skip = (s_q.ir[11:8] == 4'hb || s_q.ir[11:8] == 4'hf) && alu_z;
      end
      IOD_CLS_BIT: begin
        wr_res = ~s_q.ir[11];
        // test ops skip when the bit equals the sense bit
        skip = s_q.ir[11] && (s_q.operand[bidx] == s_q.ir[10]);
      end
      IOD_CLS_LIT: begin
        if (s_q.ir[13:12] == 2'b10) begin
          branch = 1'b1;
          target = {s_q.latch[4:3], s_q.ir[10:0]};
        end else if (s_q.ir[13:12] == 2'b11) begin
          wr_res = 1'b1;
          branch = (s_q.ir[11:10] == 2'b01);
        end else begin
          branch = (s_q.ir[6:1] == 6'h04); // both return forms
        end
      end
      default: begin
        wr_res = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // special destinations, evaluated at the last quarter
  assign go = clk_en && (s_q.ph == IOD_PH_Q4) && !s_q.nop;
  assign pcl_wr = wr_res && dest_f && (faddr == `IOD_ADDR_PCL);
  assign st_wr = wr_res && dest_f && (faddr == `IOD_ADDR_STATUS);
  assign latch_wr = wr_res && dest_f && (faddr == `IOD_ADDR_LATCH);
  assign two = skip || branch || pcl_wr;

  // source mux: pc low byte reads the live counter
  always_comb begin
    if (faddr == `IOD_ADDR_PCL) begin
      src = s_q.pc[7:0];
    end else if (faddr == `IOD_ADDR_STATUS) begin
      src = s_q.status;
    end else if (faddr == `IOD_ADDR_LATCH) begin
      src = {3'h0, s_q.latch};
    end else begin
      src = file_rdata;
    end
  end

  // flags the alu produced override the written data
  always_comb begin
    st_new = st_wr ? s_q.wdata : s_q.status;
    if (alu_flag_we[2]) begin
      st_new[`IOD_ST_Z] = alu_z;
    end
    if (alu_flag_we[1]) begin
      st_new[`IOD_ST_DC] = alu_dc;
    end
    if (alu_flag_we[0]) begin
      st_new[`IOD_ST_C] = alu_c;
    end
  end

  // ==========================================================
  // next state: four quarters, fetch and retire at the fourth
  always_comb begin
    s_d = s_q;
    s_d.ph = iod_phase_e'(s_q.ph + 2'd1);
    if (s_q.ph == IOD_PH_Q2) begin
      s_d.operand = src;
    end
    if (s_q.ph == IOD_PH_Q3) begin
      s_d.wdata = alu_result;
    end
    if (s_q.ph == IOD_PH_Q4) begin
      s_d.ir = instr_word;
      s_d.pc = s_q.pc + `IOD_PC_W'(1);
      s_d.nop = 1'b0;
      if (!s_q.nop) begin
        s_d.status = st_new;
        // latch is only touched by its own address
        if (latch_wr) begin
          s_d.latch = s_q.wdata[`IOD_LATCH_W-1:0];
        end
        if (pcl_wr) begin
          s_d.pc = {s_q.latch, s_q.wdata};
        end else if (branch) begin
          s_d.pc = target;
        end
        // the word already fetched is dropped as a nop
        s_d.nop = two;
      end
    end
  end

  // one register stage; enable low freezes everything, sys_rst still loads the reset values
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q.ph <= IOD_PH_Q1;
      s_q.ir <= `IOD_NOP_WORD;
      s_q.pc <= `IOD_PC_RST;
      s_q.latch <= `IOD_LATCH_RST;
      s_q.status <= `IOD_STATUS_RST;
      s_q.nop <= 1'b1;
      s_q.operand <= 8'h00;
      s_q.wdata <= 8'h00;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign fetch_addr = s_q.pc;
  assign exec_word = s_q.ir;
  assign exec_class = cls;
  assign exec_phase = s_q.ph;
  assign file_addr = faddr;
  assign bit_index = bidx;
  assign dest_is_file = dest_f;
  assign nop_cycle = s_q.nop;
  assign alu_operand = s_q.operand;
  assign result_data = s_q.wdata;
  assign status_reg = s_q.status;
  assign pc_high_holding_latch = s_q.latch;
  // internal specials never reach the external file
  assign file_we = go && wr_res && dest_f && !pcl_wr && !st_wr &&
                   !latch_wr;
  assign w_we = go && wr_res && !dest_f;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_four_quarters;
    (clk_en && s_q.ph == IOD_PH_Q1) ##1 clk_en [*3];
  endsequence
  sequence s_retire_two;
    go && two;
  endsequence

  a_cycle_four: assert property (
    s_four_quarters |=> s_q.ph == IOD_PH_Q1)
    else $error("instruction cycle is not four quarters");
  a_fetch_word: assert property (
    clk_en && s_q.ph == IOD_PH_Q4 |=> exec_word == $past(instr_word))
    else $error("fetched word not taken at the fourth quarter");
  a_class_bit: assert property (
    exec_word[13:12] == 2'b01
    |-> exec_class == IOD_CLS_BIT && dest_is_file == !exec_word[11]
        || exec_word[11])
    else $error("bit class misdecoded");
  a_faddr_width: assert property (
    file_addr == exec_word[6:0] && file_addr <= 7'h7f)
    else $error("file address field wrong");
  a_bit_field: assert property (
    exec_class == IOD_CLS_BIT |-> bit_index == exec_word[9:7])
    else $error("bit index field wrong");
  a_dest_route: assert property (
    (file_we |-> exec_word[7] || exec_class == IOD_CLS_BIT)
    and (w_we |-> !dest_is_file))
    else $error("result sent to the wrong destination");
  a_nop_dontcare: assert property (
    exec_word[13:7] == 7'h00 && exec_word[4:0] == 5'h00
    |-> !file_we && !w_we)
    else $error("nop with don't-care bits had an effect");
  a_two_cycle: assert property (
    s_retire_two |=> nop_cycle ##0 (!file_we && !w_we) [*4])
    else $error("second cycle is not a nop");
  a_status_clear: assert property (
    go && st_wr && result_data == 8'h00 && alu_flag_we == 3'b100
    && alu_z |=> status_reg == `IOD_STATUS_CLR)
    else $error("cleared status is not 0000 0100b");
  a_pcl_read: assert property (
    clk_en && s_q.ph == IOD_PH_Q2 && file_addr == `IOD_ADDR_PCL
    |=> alu_operand == $past(fetch_addr[7:0]))
    else $error("pc low byte read wrong");
  a_pcl_write: assert property (
    go && pcl_wr |=> fetch_addr ==
    {$past(pc_high_holding_latch), $past(result_data)}
    && $stable(pc_high_holding_latch))
    else $error("pc low write did not load the high part");
endmodule
`default_nettype wire

// ===== tb/iod_testbench.sv
// self-checking bench of the instruction operand decoder
`timescale 1ns/1ps
`default_nettype none
`include "iod_defs.svh"
module testbench;
  import iod_pkg::*;
  // ==========================================================
  // row: word, file data, alu result, flag enables, {z,c,dc},
  // class, {file write, w write, nop next, pc load}, target, operand
  typedef struct packed {
    logic [13:0] w;
    logic [7:0] rd;
    logic [7:0] res;
    logic [2:0] fwe;
    logic [2:0] zcd;
    iod_class_e cls;
    logic [3:0] ex;
    logic [12:0] tgt;
    logic [8:0] op;
  } iod_row_s;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [12:0] fetch_addr, exp_pc, tgt_p;
  logic [13:0] instr_word = 14'h0000, exec_word;
  iod_class_e exec_class;
  iod_phase_e exec_phase;
  logic [6:0] file_addr;
  logic [2:0] bit_index;
  logic [2:0] alu_flag_we = 3'h0;
  logic dest_is_file, nop_cycle, file_we, w_we;
  logic alu_z = 1'b0, alu_c = 1'b0, alu_dc = 1'b0;
  logic [7:0] alu_operand, result_data, status_reg;
  logic [7:0] alu_result = 8'h00, file_rdata = 8'h00;
  logic [4:0] pc_high_holding_latch;
  logic nop_p, br_p, chk_p;
  logic [1:0] we_p;
  logic [8:0] op_p;
  logic [7:0] res_p;
  int err_total = 0;
  int tests_run = 0;
  iod_row_s rows [21];
  // stack_top tied: return words are outside these scenarios
  iod_core u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .fetch_addr(fetch_addr), .instr_word(instr_word),
    .stack_top(13'h0000), .exec_word(exec_word), .exec_class(exec_class),
    .exec_phase(exec_phase), .file_addr(file_addr), .bit_index(bit_index),
    .dest_is_file(dest_is_file), .nop_cycle(nop_cycle),
    .alu_operand(alu_operand), .alu_result(alu_result), .alu_z(alu_z),
    .alu_c(alu_c), .alu_dc(alu_dc), .alu_flag_we(alu_flag_we),
    .file_rdata(file_rdata), .file_we(file_we), .w_we(w_we),
    .result_data(result_data), .status_reg(status_reg),
    .pc_high_holding_latch(pc_high_holding_latch));
  // 4 ns period
  always #2 ref_clk = ~ref_clk;
  // ==========================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_rst();
    #1;
    check(exec_phase, IOD_PH_Q1);
    check(fetch_addr, 13'h0000);
    check(status_reg, 8'h00);
    check(pc_high_holding_latch, 5'h00);
    check({file_we, w_we}, 2'h0);
    exp_pc = 13'h0000;
    {nop_p, br_p, chk_p} = 3'h0;
  endtask
  // word is offered in Q4 of the previous one; that word's writes are
  // judged in the same Q4, so every call overlaps the one before
  task automatic issue(input iod_row_s r);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (exec_phase !== IOD_PH_Q3 && n < 9);
    instr_word <= r.w;
    check(16'(n), 16'h0003);
    if (n == 9) final_report();
    #1;
    if (chk_p) begin
      check({file_we, w_we}, we_p);
      if (op_p[8]) check(alu_operand, op_p[7:0]);
      if (we_p != 2'h0) check(result_data, res_p);
    end
    @(posedge ref_clk);
    file_rdata <= r.rd;
    alu_result <= r.res;
    alu_flag_we <= r.fwe;
    {alu_z, alu_c, alu_dc} <= r.zcd;
    exp_pc = br_p ? tgt_p : exp_pc + 13'h0001;
    #1;
    check(nop_cycle, nop_p);
    check(fetch_addr, exp_pc);
    if (!nop_p) begin
      check(exec_word, r.w);
      check(exec_class, r.cls);
      check(file_addr, r.w[6:0]);
      check(bit_index, r.w[9:7]);
      if (r.cls == IOD_CLS_BYTE) check(dest_is_file, r.w[7]);
    end
    chk_p = 1'b1;
    we_p = nop_p ? 2'h0 : r.ex[3:2];
    op_p = nop_p ? 9'h000 : r.op;
    res_p = r.res;
    br_p = r.ex[0] & ~nop_p;
    nop_p = r.ex[1] & ~nop_p;
    tgt_p = r.tgt;
  endtask
  // ==========================================================
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk_rst();
    rows = '{
      '{14'h07a5, 8'h11, 8'h22, 3'h7, 3'h0, IOD_CLS_BYTE, 4'h8, 13'h0, 9'h0},
      '{14'h0725, 8'h11, 8'h22, 3'h7, 3'h0, IOD_CLS_BYTE, 4'h4, 13'h0, 9'h0},
      '{14'h01ff, 8'h11, 8'h00, 3'h4, 3'h4, IOD_CLS_BYTE, 4'h8, 13'h0, 9'h0},
      '{14'h0103, 8'h11, 8'h00, 3'h4, 3'h4, IOD_CLS_BYTE, 4'h4, 13'h0, 9'h0},
      '{14'h0000, 8'h00, 8'h00, 3'h0, 3'h0, IOD_CLS_BYTE, 4'h0, 13'h0, 9'h0},
      '{14'h0060, 8'h00, 8'h00, 3'h0, 3'h0, IOD_CLS_BYTE, 4'h0, 13'h0, 9'h0},
      '{14'h17a5, 8'h01, 8'h81, 3'h0, 3'h0, IOD_CLS_BIT, 4'h8, 13'h0, 9'h0},
      '{14'h1825, 8'h01, 8'h01, 3'h0, 3'h0, IOD_CLS_BIT, 4'h0, 13'h0, 9'h0},
      '{14'h1da0, 8'h08, 8'h08, 3'h0, 3'h0, IOD_CLS_BIT, 4'h2, 13'h0, 9'h0},
      '{14'h3055, 8'h00, 8'h55, 3'h0, 3'h0, IOD_CLS_LIT, 4'h4, 13'h0, 9'h0},
      '{14'h3355, 8'h00, 8'h55, 3'h0, 3'h0, IOD_CLS_LIT, 4'h4, 13'h0, 9'h0},
      '{14'h0ba5, 8'h01, 8'h00, 3'h0, 3'h4, IOD_CLS_BYTE, 4'ha, 13'h0, 9'h0},
      '{14'h0a25, 8'h01, 8'h02, 3'h0, 3'h0, IOD_CLS_BYTE, 4'h4, 13'h0, 9'h0},
      '{14'h008a, 8'h00, 8'h15, 3'h0, 3'h0, IOD_CLS_BYTE, 4'h0, 13'h0, 9'h0},
      '{14'h0082, 8'h00, 8'h40, 3'h0, 3'h0, IOD_CLS_BYTE, 4'h3, 13'h1540, 9'h0},
      '{14'h3000, 8'h00, 8'h00, 3'h0, 3'h0, IOD_CLS_LIT, 4'h4, 13'h0, 9'h0},
      '{14'h2923, 8'h00, 8'h00, 3'h0, 3'h0, IOD_CLS_LIT, 4'h3, 13'h1123, 9'h0},
      '{14'h0000, 8'h00, 8'h00, 3'h0, 3'h0, IOD_CLS_BYTE, 4'h0, 13'h0, 9'h0},
      '{14'h0802, 8'h55, 8'h24, 3'h0, 3'h0, IOD_CLS_BYTE, 4'h4, 13'h0, 9'h124},
      '{14'h0a82, 8'h55, 8'h80, 3'h0, 3'h0, IOD_CLS_BYTE, 4'h3, 13'h1580,
        9'h125},
      '{14'h0000, 8'h00, 8'h00, 3'h0, 3'h0, IOD_CLS_BYTE, 4'h0, 13'h0, 9'h0}};
    foreach (rows[i]) issue(rows[i]);
    check(pc_high_holding_latch, 5'h15);
    // flags override the written data; clear leaves only zero set
    issue('{14'h0783, 8'h00, 8'h01, 3'h7, 3'h5, IOD_CLS_BYTE, 4'h0, 13'h0,
      9'h0});
    issue('{14'h0183, 8'h5a, 8'h00, 3'h4, 3'h4, IOD_CLS_BYTE, 4'h0, 13'h0,
      9'h0});
    check(status_reg, 8'h06);
    issue(rows[4]);
    check(status_reg, 8'h04);
    // enable low freezes the quarter count
    @(posedge ref_clk);
    clk_en <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    check(exec_phase, IOD_PH_Q2);
    check(fetch_addr, exp_pc);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    // second reset in mid-run, then restart from address zero
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk_rst();
    issue(rows[4]);
    issue(rows[10]);
    issue(rows[4]);
    final_report();
  end
endmodule
`default_nettype wire
